// *** hw/rtcc_pkg.sv ***
// rtcc_pkg: offsets, field positions, reset values and timing counts of the
// real-time-clock control/status register block.
// assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
`default_nettype none

package rtcc_pkg;

  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam longint unsigned CLK_HZ = 100_000_000;
  localparam longint unsigned COMP_PERIOD_S = 64;  // periodic compensation, seconds
  localparam longint unsigned COMP_PERIOD_CYC = COMP_PERIOD_S * CLK_HZ;
  localparam longint unsigned FREQ_1HZ = 1;
  localparam longint unsigned FREQ_1K = 1024;
  localparam longint unsigned FREQ_4K = 4096;
  localparam longint unsigned FREQ_8K = 8192;
  localparam longint unsigned FREQ_32K = 32768;
  // half periods in clock cycles, rounded down
  localparam longint unsigned HALF_1HZ = CLK_HZ / (2 * FREQ_1HZ);
  localparam longint unsigned HALF_1K = CLK_HZ / (2 * FREQ_1K);
  localparam longint unsigned HALF_4K = CLK_HZ / (2 * FREQ_4K);
  localparam longint unsigned HALF_8K = CLK_HZ / (2 * FREQ_8K);
  localparam logic [10:0] HALF_32K = 11'(CLK_HZ / (2 * FREQ_32K));

  // ----------------------------------------
  // register map: index, byte address is four times the index
  // ----------------------------------------
  localparam logic [5:0] IDX_CONTROL = 6'h0E;
  localparam logic [5:0] IDX_STATUS = 6'h0F;
  localparam logic [5:0] IDX_AGING = 6'h10;

  // control fields
  localparam int CTL_OSC_STOP = 7;
  localparam int CTL_BATT_WAVE = 6;
  localparam int CTL_FORCE_FORCE_CONVERT = 5;
  localparam int CTL_RATE_HI = 4;
  localparam int CTL_RATE_LO = 3;
  localparam int CTL_IRQ_MODE = 2;
  localparam int CTL_A2_IE = 1;
  localparam int CTL_A1_IE = 0;
  // status fields
  localparam int STA_OSF = 7;
  localparam int STA_CLK32_EN = 3;
  localparam int STA_BUSY = 2;
  localparam int STA_A2F = 1;
  localparam int STA_A1F = 0;

  localparam logic [7:0] CONTROL_RESET = 8'h1C;
  localparam logic [7:0] AGING_RESET = 8'h00;
  localparam logic [1:0] RATE_1HZ = 2'h0;
  localparam logic [1:0] RATE_1K = 2'h1;
  localparam logic [1:0] RATE_4K = 2'h2;
  localparam logic [1:0] RATE_8K = 2'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RTCC_IDLE = 2'b00,
    RTCC_CONVERT = 2'b01,
    RTCC_COMPENSATE = 2'b10
  } rtcc_comp_state_e;

endpackage : rtcc_pkg

`default_nettype wire

// *** hw/rtcc_comp.sv ***
// rtcc_comp: temperature conversion and load-capacitance compensation sequencer.
// assumes a temperature sensor on the same clock answering a request with a
// one-cycle done pulse, and a compensation code valid when done arrives.
`default_nettype none

module rtcc_comp (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_start_periodic,
  input wire logic i_start_forced,
  input wire logic i_temp_done,
  input wire logic [7:0] i_cap_code,
  input wire logic [7:0] i_aging,
  output logic o_temp_req,
  output logic o_busy,
  output logic o_forced_run,
  output logic [7:0] o_load_cap
);
  import rtcc_pkg::*;

  rtcc_comp_state_e state_q;
  logic signed [8:0] sum;

  // --------------------------------
  // sequencer
  // --------------------------------
  // a start while busy is dropped so a running pass is never aborted
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      state_q <= RTCC_IDLE;
    end else begin
      unique case (state_q)
        RTCC_IDLE: begin
          if (i_start_periodic || i_start_forced) begin
            state_q <= RTCC_CONVERT;
          end
        end
        RTCC_CONVERT: begin
          if (i_temp_done) begin
            state_q <= RTCC_COMPENSATE;
          end
        end
        RTCC_COMPENSATE: begin
          state_q <= RTCC_IDLE;
        end
        default: begin
          state_q <= RTCC_IDLE;
        end
      endcase
    end
  end

  // busy from request to return to idle
  assign o_busy = (state_q != RTCC_IDLE);
  assign o_temp_req = (state_q == RTCC_CONVERT);

  // remembers whether software alone started the running pass; a periodic start in the same cycle leaves it 0
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_forced_run <= 1'b0;
    end else if (state_q == RTCC_IDLE) begin
      o_forced_run <= i_start_forced && !i_start_periodic;
    end
  end

  // --------------------------------
  // load capacitance with aging trim
  // --------------------------------
  // signed sum saturates so one step never wraps the whole array
  assign sum = 9'(signed'(i_cap_code)) + 9'(signed'(i_aging));

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_load_cap <= 8'h00;
    end else if (state_q == RTCC_COMPENSATE) begin
      if (sum > 9'sh07F) begin
        o_load_cap <= 8'h7F;
      end else if (sum < -9'sh080) begin
        o_load_cap <= 8'h80;
      end else begin
        o_load_cap <= sum[7:0];
      end
    end
  end

endmodule : rtcc_comp

`default_nettype wire

// *** hw/rtcc_regs.sv ***
// rtcc_regs: control, status and aging trim registers of a temperature-
// compensated real-time clock, with the shared interrupt/wave pin and the
// 32.768 kHz output, reached over AXI4-Lite.
// assumes alarm match pulses and sensor handshakes on i_clock; supply status
// and crystal-fault inputs come from outside and are synchronised here.
//
// Operation
// - osc_stop_on_battery (bit 7) halts the oscillator only on backup supply.
// - battery_wave_enable low floats the shared pin while on backup supply.
// - writing force_convert while idle starts conversion; ignored while busy.
// - software conversions leave the 64-second periodic schedule untouched.
// - rate select 00/01/10/11 gives 1Hz/1.024kHz/4.096kHz/8.192kHz.
// - control resets to rates 11, irq mode 1, all other bits 0.
// - irq_mode_select 0 puts square wave on pin; 1 makes active-low interrupt.
// - interrupt asserts when irq mode set and any enabled alarm flag set.
// - alarm flags set on match regardless of mode and enable bits.
// - alarm2_flag is bit 1, alarm1_flag bit 0, set on time match.
// - writing 0 clears an alarm flag; writing 1 leaves it unchanged.
// - osc_stopped_flag sets when the oscillator stops, stays until written 0.
// - osc_stopped_flag set at power-up and on stop-on-battery halt.
// - clk32_out_enable (status bit 3) drives 32.768kHz or floats the output.
// - clk32_out_enable resets to 1.
// - comp_busy rises with conversion request, clears on return to idle.
// - aging trim is 8-bit two's complement added to capacitance codes.
// - each trim step switches one unit capacitor in or out.
//
// Design decision made here: the AXI4-Lite register port.
`default_nettype none

module rtcc_regs #(
  parameter int ADDR_W = 8,
  parameter logic [25:0] HALF_1HZ_CYC = 26'(rtcc_pkg::HALF_1HZ),
  parameter logic [25:0] HALF_1K_CYC = 26'(rtcc_pkg::HALF_1K),
  parameter logic [25:0] HALF_4K_CYC = 26'(rtcc_pkg::HALF_4K),
  parameter logic [25:0] HALF_8K_CYC = 26'(rtcc_pkg::HALF_8K),
  parameter logic [32:0] PERIOD_CYC = 33'(rtcc_pkg::COMP_PERIOD_CYC)
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  // axi4-lite slave
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [ADDR_W-1:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // surroundings
  input wire logic i_on_battery,
  input wire logic i_osc_fault,
  input wire logic i_alarm1_match,
  input wire logic i_alarm2_match,
  input wire logic i_temp_done,
  input wire logic [7:0] i_cap_code,
  output logic o_temp_req,
  output logic [7:0] o_load_cap,
  output logic o_osc_run,
  output logic o_irq_or_wave_out,
  output logic o_irq_or_wave_oe_n,
  output logic o_clk32_out,
  output logic o_clk32_oe_n
);
  import rtcc_pkg::*;

  if (ADDR_W < 8 || PERIOD_CYC < 33'd2 || HALF_8K_CYC == 26'd0) begin : g_bad_param
    $error("rtcc_regs: address width or cycle counts too small");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [1:0] sync1_q, sync2_q;
  logic [7:0] control_q, aging_q;
  logic osf_q, clk32_en_q, a1f_q, a2f_q;
  logic aw_have_q, w_have_q;
  logic [ADDR_W-1:0] awaddr_q, araddr_q;
  logic [7:0] wdata_q;
  logic wlane_q;
  logic force_q;
  logic [32:0] per_cnt_q;
  logic [25:0] wave_cnt_q;
  logic wave_q;
  logic [10:0] c32_cnt_q;
  logic c32_q;
  logic busy, forced_run, on_batt, wr_fire, ctl_wr, sta_wr, osc_halt, irq_active;
  logic [25:0] half_sel;
  logic [7:0] status_word;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // supply status and crystal fault are asynchronous to i_clock
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
    end else begin
      sync1_q <= {i_osc_fault, i_on_battery};
      sync2_q <= sync1_q;
    end
  end
  assign on_batt = sync2_q[0];

  // ----------------------------------------
  // axi4-lite write path
  // ----------------------------------------
  // address and data are taken in either order; response once both are held
  assign wr_fire = aw_have_q && w_have_q && !o_bvalid;
  assign ctl_wr = wr_fire && wlane_q && (awaddr_q[ADDR_W-1:2] == (ADDR_W-2)'(IDX_CONTROL));
  assign sta_wr = wr_fire && wlane_q && (awaddr_q[ADDR_W-1:2] == (ADDR_W-2)'(IDX_STATUS));

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      aw_have_q <= 1'b0;
      o_awready <= 1'b1;
      awaddr_q <= '0;
    end else if (i_awvalid && o_awready) begin
      aw_have_q <= 1'b1;
      o_awready <= 1'b0;
      awaddr_q <= i_awaddr;
    end else if (o_bvalid && i_bready) begin
      aw_have_q <= 1'b0;
      o_awready <= 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      w_have_q <= 1'b0;
      o_wready <= 1'b1;
      wdata_q <= 8'h00;
      wlane_q <= 1'b0;
    end else if (i_wvalid && o_wready) begin
      w_have_q <= 1'b1;
      o_wready <= 1'b0;
      wdata_q <= i_wdata[7:0];
      wlane_q <= i_wstrb[0];  // upper lanes hold only read-as-zero bits
    end else if (o_bvalid && i_bready) begin
      w_have_q <= 1'b0;
      o_wready <= 1'b1;
    end
  end

  // write response; unmapped addresses answer slverr
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_bvalid <= 1'b0;
      o_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      o_bvalid <= 1'b1;
      o_bresp <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-3:0] idx;
    idx = a[ADDR_W-1:2];
    return idx == (ADDR_W-2)'(IDX_CONTROL) || idx == (ADDR_W-2)'(IDX_STATUS) ||
           idx == (ADDR_W-2)'(IDX_AGING);
  endfunction : mapped

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  // force_convert is not stored; it reads back as a running software pass
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      control_q <= CONTROL_RESET;
      aging_q <= AGING_RESET;
    end else begin
      if (ctl_wr) begin
        control_q <= wdata_q & ~(8'h01 << CTL_FORCE_FORCE_CONVERT);
      end
      if (wr_fire && wlane_q && awaddr_q[ADDR_W-1:2] == (ADDR_W-2)'(IDX_AGING)) begin
        aging_q <= wdata_q;
      end
    end
  end

  // one-cycle start request; dropped while a pass is running
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      force_q <= 1'b0;
    end else begin
      force_q <= ctl_wr && wdata_q[CTL_FORCE_FORCE_CONVERT] && !busy;
    end
  end

  // status enable bit, writes to bits 6..4 have nowhere to go
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      clk32_en_q <= 1'b1;
    end else if (sta_wr) begin
      clk32_en_q <= wdata_q[STA_CLK32_EN];
    end
  end

  // ----------------------------------------
  // sticky flags: a set in the clearing cycle wins
  // ----------------------------------------
  assign osc_halt = (control_q[CTL_OSC_STOP] && on_batt) || sync2_q[1];

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      osf_q <= 1'b1;
      a1f_q <= 1'b0;
      a2f_q <= 1'b0;
    end else begin
      osf_q <= osc_halt || (osf_q && !(sta_wr && !wdata_q[STA_OSF]));
      a1f_q <= i_alarm1_match || (a1f_q && !(sta_wr && !wdata_q[STA_A1F]));
      a2f_q <= i_alarm2_match || (a2f_q && !(sta_wr && !wdata_q[STA_A2F]));
    end
  end

  assign status_word = {osf_q, 3'b000, clk32_en_q, busy, a2f_q, a1f_q};

  // ----------------------------------------
  // axi4-lite read path
  // ----------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= RESP_OKAY;
      araddr_q <= '0;
    end else if (i_arvalid && o_arready) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      araddr_q <= i_araddr;
      o_rresp <= mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
      if (i_araddr[ADDR_W-1:2] == (ADDR_W-2)'(IDX_CONTROL)) begin
        o_rdata <= {24'h00_0000, control_q | (8'(forced_run) << CTL_FORCE_FORCE_CONVERT)};
      end else if (i_araddr[ADDR_W-1:2] == (ADDR_W-2)'(IDX_STATUS)) begin
        o_rdata <= {24'h00_0000, status_word};
      end else if (i_araddr[ADDR_W-1:2] == (ADDR_W-2)'(IDX_AGING)) begin
        o_rdata <= {24'h00_0000, aging_q};
      end else begin
        o_rdata <= 32'h0000_0000;
      end
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  // ----------------------------------------
  // periodic compensation schedule
  // ----------------------------------------
  // free-running, never touched by software starts; fires right after reset, then every PERIOD_CYC cycles
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      per_cnt_q <= 33'd0;
    end else if (per_cnt_q == PERIOD_CYC - 33'd1) begin
      per_cnt_q <= 33'd0;
    end else begin
      per_cnt_q <= per_cnt_q + 33'd1;
    end
  end

  rtcc_comp u_comp (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_start_periodic(per_cnt_q == 33'd0),
    .i_start_forced(force_q),
    .i_temp_done(i_temp_done),
    .i_cap_code(i_cap_code),
    .i_aging(aging_q),
    .o_temp_req(o_temp_req),
    .o_busy(busy),
    .o_forced_run(forced_run),
    .o_load_cap(o_load_cap)
  );

  // ----------------------------------------
  // square waves
  // ----------------------------------------
  always_comb begin
    unique case (control_q[CTL_RATE_HI:CTL_RATE_LO])
      RATE_1HZ: half_sel = HALF_1HZ_CYC;
      RATE_1K: half_sel = HALF_1K_CYC;
      RATE_4K: half_sel = HALF_4K_CYC;
      RATE_8K: half_sel = HALF_8K_CYC;
    endcase
  end

  // compare with >= so a rate change to a shorter period cannot overrun
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      wave_cnt_q <= 26'd0;
      wave_q <= 1'b0;
    end else if (wave_cnt_q >= half_sel - 26'd1) begin
      wave_cnt_q <= 26'd0;
      wave_q <= !wave_q;
    end else begin
      wave_cnt_q <= wave_cnt_q + 26'd1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      c32_cnt_q <= 11'd0;
      c32_q <= 1'b0;
    end else if (c32_cnt_q == HALF_32K - 11'd1) begin
      c32_cnt_q <= 11'd0;
      c32_q <= !c32_q;
    end else begin
      c32_cnt_q <= c32_cnt_q + 11'd1;
    end
  end

  // ----------------------------------------
  // pins and oscillator gate
  // ----------------------------------------
  assign irq_active = (a1f_q && control_q[CTL_A1_IE]) || (a2f_q && control_q[CTL_A2_IE]);

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_irq_or_wave_out <= 1'b1;
      o_irq_or_wave_oe_n <= 1'b1;
      o_clk32_out <= 1'b0;
      o_clk32_oe_n <= 1'b1;
      o_osc_run <= 1'b1;
    end else begin
      o_osc_run <= !(control_q[CTL_OSC_STOP] && on_batt);
      o_clk32_out <= c32_q;
      o_clk32_oe_n <= !clk32_en_q;
      if (on_batt && !control_q[CTL_BATT_WAVE]) begin
        o_irq_or_wave_out <= 1'b1;
        o_irq_or_wave_oe_n <= 1'b1;
      end else if (control_q[CTL_IRQ_MODE]) begin
        o_irq_or_wave_out <= 1'b0;
        o_irq_or_wave_oe_n <= !irq_active;
      end else begin
        o_irq_or_wave_out <= wave_q;
        o_irq_or_wave_oe_n <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  a_osc_gate: assert property (
    on_batt && control_q[CTL_OSC_STOP] |=> !o_osc_run)
    else $error("oscillator not halted on battery with stop bit set");
  a_batt_float: assert property (
    on_batt && !control_q[CTL_BATT_WAVE] |=> o_irq_or_wave_oe_n)
    else $error("shared pin driven on battery without wave enable");
  a_force_start: assert property (
    ctl_wr && wdata_q[CTL_FORCE_FORCE_CONVERT] && !busy |=> ##1 busy)
    else $error("forced conversion did not start");
  a_period_steady: assert property (
    per_cnt_q != PERIOD_CYC - 33'd1 |=> per_cnt_q == $past(per_cnt_q) + 33'd1)
    else $error("periodic schedule disturbed");
  a_irq_drive: assert property (
    control_q[CTL_IRQ_MODE] && irq_active && !on_batt
    |=> !o_irq_or_wave_oe_n && !o_irq_or_wave_out)
    else $error("interrupt not driven low");
  a_wave_mode: assert property (
    !control_q[CTL_IRQ_MODE] && !on_batt |=> !o_irq_or_wave_oe_n && o_irq_or_wave_out == $past(wave_q))
    else $error("square wave not on shared pin");
  a_alarm_set: assert property (
    i_alarm1_match ##1 !(sta_wr && !wdata_q[STA_A1F]) |-> a1f_q)
    else $error("alarm 1 flag lost");
  a_flag_clear: assert property (
    sta_wr && !wdata_q[STA_A2F] && !i_alarm2_match |=> !a2f_q)
    else $error("alarm 2 flag not cleared by zero write");
  a_osf_sticky: assert property (
    osf_q && !(sta_wr && !wdata_q[STA_OSF]) |=> osf_q)
    else $error("oscillator stop flag dropped without write");
  a_busy_ends: assert property (
    busy && o_temp_req && i_temp_done |=> ##1 !busy)
    else $error("busy not cleared after compensation");
  a_status_zero: assert property (
    o_rvalid && araddr_q[ADDR_W-1:2] == (ADDR_W-2)'(IDX_STATUS) |-> o_rdata[6:4] == 3'b000)
    else $error("status reserved bits not zero");

  c_forced_pass: cover property (force_q ##[1:20] i_temp_done);
  c_irq_low: cover property (!o_irq_or_wave_oe_n && control_q[CTL_IRQ_MODE]);
  c_osf_cleared: cover property (osf_q ##1 !osf_q);
  c_unmapped_rd: cover property (o_rvalid && o_rresp == RESP_SLVERR);

endmodule : rtcc_regs

`default_nettype wire

// *** testbench/tb_rtc_control_status_regs.sv ***
// tb_rtc_control_status_regs: self-checking bench for the rtcc_regs block.
// assumes rtcc_pkg and rtcc_regs compiled first; the bench is the bus master.
`default_nettype none
module tb_rtc_control_status_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import rtcc_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  typedef struct packed {logic [5:0] idx; logic [7:0] wd; logic [7:0] ex; logic [7:0] mk;
    logic [1:0] rs;} rtcc_row_s;
  localparam int HALF [4] = '{40, 20, 10, 6};
  logic i_clock, i_resetn, awv, wv, bre, arv, rre, bat, a1, a2, tdone, awr, wrd, bv, arr, rv;
  logic treq, osc_run, pin, pin_oe_n, c32, c32_oe_n, p;
  logic [7:0] awa, ara, cap, load;
  logic [31:0] wd, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [3:0] dly;
  int miscompares, n_tests, n;
  rtcc_row_s rows [6];
  rtcc_regs #(.HALF_1HZ_CYC(26'(40)), .HALF_1K_CYC(26'(20)), .HALF_4K_CYC(26'(10)),
    .HALF_8K_CYC(26'(6)), .PERIOD_CYC(33'(200))) dut (.i_clock(i_clock), .i_resetn(i_resetn),
    .i_awvalid(awv), .o_awready(awr), .i_awaddr(awa), .i_wvalid(wv), .o_wready(wrd),
    .i_wdata(wd), .i_wstrb(4'hF), .o_bvalid(bv), .i_bready(bre), .o_bresp(bresp),
    .i_arvalid(arv), .o_arready(arr), .i_araddr(ara), .o_rvalid(rv), .i_rready(rre),
    .o_rdata(rdata), .o_rresp(rresp), .i_on_battery(bat), .i_osc_fault(1'b0),
    .i_alarm1_match(a1), .i_alarm2_match(a2), .i_temp_done(tdone), .i_cap_code(cap),
    .o_temp_req(treq), .o_load_cap(load), .o_osc_run(osc_run), .o_irq_or_wave_out(pin),
    .o_irq_or_wave_oe_n(pin_oe_n), .o_clk32_out(c32), .o_clk32_oe_n(c32_oe_n));
  // ----------------------------------------
  // clock, sensor stand-in, tasks
  // ----------------------------------------
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  // sensor answers after eight cycles so that busy is long enough to be read
  always @(posedge i_clock) begin
    dly <= treq ? dly + 4'h1 : 4'h0;
    tdone <= treq && dly == 4'h7;
  end
  task automatic chk_v(input logic [31:0] got, input logic [31:0] ex);
    n_tests++;
    if (got !== ex) begin
      miscompares++;
      $display("ERROR at %0t: value %h expected %h", $time, got, ex);
    end
  endtask : chk_v
  task automatic chk_p(input logic got, input logic ex);
    n_tests++;
    if (got !== ex) begin
      miscompares++;
      $display("ERROR at %0t: pin %b expected %b", $time, got, ex);
    end
  endtask : chk_p
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [5:0] a, input logic [7:0] v, output logic [1:0] rs);
    logic ad, dd;
    ad = 0;
    dd = 0;
    @(posedge i_clock);
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= {a, 2'h0};
    wd <= {24'h0, v};
    bre <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge i_clock);
      if (!ad && awr) begin ad = 1; awv <= 1'b0; end
      if (!dd && wrd) begin dd = 1; wv <= 1'b0; end
    end
    while (!bv) @(posedge i_clock);
    rs = bresp;
    bre <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge i_clock);
    arv <= 1'b1;
    ara <= {a, 2'h0};
    rre <= 1'b1;
    do @(posedge i_clock); while (!arr);
    arv <= 1'b0;
    do @(posedge i_clock); while (!rv);
    v = rdata;
    rs = rresp;
    rre <= 1'b0;
  endtask : rd
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  // hang guard, generous against the few thousand cycles the tests take
  initial begin
    repeat (30000) @(posedge i_clock);
    miscompares++;
    $display("ERROR at %0t: watchdog expired", $time);
    report_and_stop;
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    i_resetn = 0; awv = 0; wv = 0; bre = 0; arv = 0; rre = 0; awa = 0; ara = 0; wd = 0;
    bat = 0; a1 = 0; a2 = 0; cap = 8'h10; miscompares = 0; n_tests = 0;
    // index, write, expected read, mask, response
    rows = '{'{IDX_CONTROL, 8'h5B, 8'h5B, 8'hFF, RESP_OKAY},
      '{IDX_CONTROL, 8'h1C, 8'h1C, 8'hFF, RESP_OKAY}, '{IDX_AGING, 8'h80, 8'h80, 8'hFF, RESP_OKAY},
      '{IDX_STATUS, 8'h70, 8'h00, 8'hFB, RESP_OKAY}, '{IDX_STATUS, 8'h0B, 8'h08, 8'hFB, RESP_OKAY},
      '{6'h11, 8'hFF, 8'h00, 8'hFF, RESP_SLVERR}};
    repeat (3) @(posedge i_clock);
    i_resetn <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].wd, r);
      chk_v(32'(r), 32'(rows[i].rs));
      rd(rows[i].idx, d, r);
      chk_v(32'(r), 32'(rows[i].rs));
      chk_v(d & {24'h0, rows[i].mk}, {24'h0, rows[i].ex});
      $display("row %0d done", i);
    end
    for (int k = 0; k < 4; k++) begin
      wr(IDX_CONTROL, 8'(k << 3), r);
      repeat (2) begin p = pin; do @(posedge i_clock); while (pin === p); end
      p = pin;
      n = 0;
      do begin @(posedge i_clock); n++; end while (pin === p);
      chk_v(32'(n), 32'(HALF[k]));
      chk_p(pin_oe_n, 1'b0);
    end
    $display("wave rates done");
    wr(IDX_CONTROL, 8'h05, r);
    @(posedge i_clock); a1 <= 1'b1; @(posedge i_clock); a1 <= 1'b0;
    @(posedge i_clock); a2 <= 1'b1; @(posedge i_clock); a2 <= 1'b0;
    repeat (3) @(posedge i_clock);
    chk_p(pin, 1'b0);
    chk_p(pin_oe_n, 1'b0);
    wr(IDX_STATUS, 8'h0A, r);
    repeat (2) @(posedge i_clock);
    chk_p(pin_oe_n, 1'b1);
    rd(IDX_STATUS, d, r);
    chk_v(d & 32'h3, 32'h2);
    wr(IDX_STATUS, 8'h00, r);
    repeat (2) @(posedge i_clock);
    chk_p(c32_oe_n, 1'b1);
    wr(IDX_STATUS, 8'h08, r);
    repeat (2) @(posedge i_clock);
    chk_p(c32_oe_n, 1'b0);
    // the 32.768 kHz half period is fixed, not shortened by a parameter
    p = c32;
    do @(posedge i_clock); while (c32 === p);
    p = c32;
    n = 0;
    do begin @(posedge i_clock); n++; end while (c32 === p);
    chk_v(32'(n), 32'(HALF_32K));
    $display("alarm and clk32 done");
    wr(IDX_CONTROL, 8'h80, r);
    repeat (6) @(posedge i_clock);
    chk_p(osc_run, 1'b1);
    bat <= 1'b1;
    repeat (6) @(posedge i_clock);
    chk_p(osc_run, 1'b0);
    chk_p(pin_oe_n, 1'b1);
    rd(IDX_STATUS, d, r);
    chk_v(d & 32'h80, 32'h80);
    wr(IDX_CONTROL, 8'h40, r);
    repeat (3) @(posedge i_clock);
    chk_p(osc_run, 1'b1);
    chk_p(pin_oe_n, 1'b0);
    bat <= 1'b0;
    repeat (6) @(posedge i_clock);
    wr(IDX_STATUS, 8'h08, r);
    rd(IDX_STATUS, d, r);
    chk_v(d & 32'h80, 32'h00);
    $display("battery done");
    wr(IDX_AGING, 8'hFE, r);
    do rd(IDX_STATUS, d, r); while (d[2] !== 1'b0);
    wr(IDX_CONTROL, 8'h3C, r);
    repeat (3) @(posedge i_clock);
    rd(IDX_STATUS, d, r);
    chk_v(d & 32'h4, 32'h4);
    rd(IDX_CONTROL, d, r);
    chk_v(d & 32'h20, 32'h20);
    do rd(IDX_STATUS, d, r); while (d[2] !== 1'b0);
    chk_v(32'(load), 32'h0E);
    $display("conversion done");
    i_resetn <= 1'b0;
    repeat (3) @(posedge i_clock);
    i_resetn <= 1'b1;
    rd(IDX_CONTROL, d, r);
    chk_v(d, 32'h1C);
    rd(IDX_STATUS, d, r);
    chk_v(d & 32'hFB, 32'h88);
    rd(IDX_AGING, d, r);
    chk_v(d, 32'h00);
    $display("reset done");
    report_and_stop;
  end
endmodule : tb_rtc_control_status_regs
`default_nettype wire
